// ===== hw/led_fade_channel.sv
// Purpose: One fade-capable LED channel: ON, fade-out, OFF and fade-in timing.
// Assumes: AXI4-Lite slave; the LED sinks into an open-drain pin.
// Notes:   Byte lane 0 carries all write data; upper bits read as zero except STATUS bits 8 to 10.
`timescale 1ns/1ns

module led_fade_channel (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read.
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Open-drain LED pin.
  input  wire logic        led_pin_sense,
  output logic             led_pin_value,
  output logic             led_pin_oe
);
  led_fade_pkg::led_cfg_t cfg_r;
  led_fade_pkg::phase_t   phase_r;
  logic        data_r;
  logic        aw_held_r;
  logic        w_held_r;
  logic [7:0]  awaddr_r;
  logic [7:0]  wbyte_r;
  logic        wlane_r;
  logic [7:0]  level_r;
  logic [13:0] dur_r;
  logic [8:0]  step_r;
  logic [7:0]  pwm_r;
  logic        oe_r;
  logic        enabled;
  logic        led_driver_clock_tick;
  logic        unit_tick;
  logic [7:0]  duty;
  logic [7:0]  off_level;
  logic        do_write;

  function automatic logic addr_hit(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= led_fade_pkg::ADDR_STATUS;
  endfunction : addr_hit

  // Phase length in 255-period units for an ON or OFF time field.
  function automatic logic [13:0] span_units(input logic [4:0] v);
    if (int'(v) < led_fade_pkg::FAST_LIMIT) begin
      return 14'(led_fade_pkg::SPAN_FAST * int'(v));
    end
    return 14'(led_fade_pkg::SPAN_SLOW * int'(v));
  endfunction : span_units

  // Units between two one-step intensity moves of a ramp.
  function automatic logic [8:0] ramp_units(input logic [4:0] v);
    if (int'(v) < led_fade_pkg::FAST_LIMIT) begin
      return 9'(v);
    end
    return 9'(led_fade_pkg::FADE_SLOW * int'(v));
  endfunction : ramp_units

  function automatic logic [7:0] step_toward(input logic [7:0] cur, input logic [7:0] tgt);
    return (cur < tgt) ? cur + 8'h01 : cur - 8'h01;
  endfunction : step_toward

  assign enabled   = cfg_r.div != 3'h0;
  assign off_level = 8'(led_fade_pkg::OFF_INT_SCALE * int'(cfg_r.off_int));

  led_tick_gen u_ticks (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .div       (cfg_r.div),
    .led_driver_clock_tick (led_driver_clock_tick),
    .unit_tick (unit_tick)
  );

  led_level_map u_map (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .log_mode  (cfg_r.log_mode),
    .level_in  (level_r),
    .level_out (duty)
  );

  // Write channel: address and data are taken independently, the response after both.
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign do_write      = aw_held_r && w_held_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r  <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r  <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wbyte_r  <= 8'h00;
      wlane_r  <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      wbyte_r  <= s_axi_wdata[7:0];
      wlane_r  <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= led_fade_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (addr_hit(awaddr_r) && awaddr_r != led_fade_pkg::ADDR_STATUS) ?
                      led_fade_pkg::RESP_OKAY : led_fade_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register file.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r          <= '0;
      cfg_r.on_int   <= led_fade_pkg::RST_ON_INT;
      data_r         <= led_fade_pkg::RST_DATA;
    end else if (do_write && wlane_r) begin
      unique case (awaddr_r)
        led_fade_pkg::ADDR_ON_TIME: cfg_r.on_time <= wbyte_r[4:0];
        led_fade_pkg::ADDR_ON_INT:  cfg_r.on_int  <= wbyte_r;
        led_fade_pkg::ADDR_OFF: begin
          cfg_r.off_time <= wbyte_r[7:led_fade_pkg::OFF_TIME_LO];
          cfg_r.off_int  <= wbyte_r[led_fade_pkg::OFF_INT_HI:0];
        end
        led_fade_pkg::ADDR_RISE: cfg_r.rise <= wbyte_r[4:0];
        led_fade_pkg::ADDR_FALL: cfg_r.fall <= wbyte_r[4:0];
        led_fade_pkg::ADDR_MISC: begin
          cfg_r.div      <= wbyte_r[led_fade_pkg::MISC_DIV_LO +: 3];
          cfg_r.log_mode <= wbyte_r[led_fade_pkg::MISC_MODE];
        end
        led_fade_pkg::ADDR_DATA: data_r <= wbyte_r[0];
        default: ;
      endcase
    end
  end

  // Read channel: one read at a time, data registered.
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= led_fade_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= addr_hit(s_axi_araddr) ? led_fade_pkg::RESP_OKAY : led_fade_pkg::RESP_SLVERR;
      unique case (s_axi_araddr)
        led_fade_pkg::ADDR_ON_TIME: s_axi_rdata <= {27'h0, cfg_r.on_time};
        led_fade_pkg::ADDR_ON_INT:  s_axi_rdata <= {24'h0, cfg_r.on_int};
        led_fade_pkg::ADDR_OFF:     s_axi_rdata <= {24'h0, cfg_r.off_time, cfg_r.off_int};
        led_fade_pkg::ADDR_RISE:    s_axi_rdata <= {27'h0, cfg_r.rise};
        led_fade_pkg::ADDR_FALL:    s_axi_rdata <= {27'h0, cfg_r.fall};
        led_fade_pkg::ADDR_MISC:    s_axi_rdata <= {25'h0, cfg_r.div, cfg_r.log_mode, 3'h0};
        led_fade_pkg::ADDR_DATA:    s_axi_rdata <= {31'h0, data_r};
        led_fade_pkg::ADDR_STATUS:  s_axi_rdata <= {21'h0, led_pin_sense, phase_r, level_r};
        default:                    s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Phase engine. Durations count time units; ramps move one intensity step
  // per ramp interval, so the ramp length scales with the ON minus OFF span.
  always_ff @(posedge aclk) begin
    if (!aresetn || !enabled) begin
      phase_r <= led_fade_pkg::PH_ON;
      level_r <= 8'h00;
      dur_r   <= 14'h0000;
      step_r  <= 9'h000;
    end else begin
      unique case (phase_r)
        led_fade_pkg::PH_ON: begin
          level_r <= cfg_r.on_int;
          if (cfg_r.on_time == 5'h00 ? data_r :
              (unit_tick && dur_r + 14'h0001 >= span_units(cfg_r.on_time))) begin
            phase_r <= led_fade_pkg::PH_FALL;
            dur_r   <= 14'h0000;
            step_r  <= 9'h000;
          end else if (unit_tick && cfg_r.on_time != 5'h00) begin
            dur_r <= dur_r + 14'h0001;
          end
        end
        led_fade_pkg::PH_FALL: begin
          if (cfg_r.fall == 5'h00 || level_r == off_level) begin
            level_r <= off_level;
            phase_r <= led_fade_pkg::PH_OFF;
            step_r  <= 9'h000;
          end else if (unit_tick && step_r + 9'h001 >= ramp_units(cfg_r.fall)) begin
            level_r <= step_toward(level_r, off_level);
            step_r  <= 9'h000;
          end else if (unit_tick) begin
            step_r <= step_r + 9'h001;
          end
        end
        led_fade_pkg::PH_OFF: begin
          level_r <= off_level;
          // A zero OFF time holds the OFF phase and intensity while the data bit stays high.
          if (cfg_r.off_time == 5'h00 ? !data_r :
              (unit_tick && dur_r + 14'h0001 >= span_units(cfg_r.off_time))) begin
            phase_r <= led_fade_pkg::PH_RISE;
            dur_r   <= 14'h0000;
            step_r  <= 9'h000;
          end else if (unit_tick && cfg_r.off_time != 5'h00) begin
            dur_r <= dur_r + 14'h0001;
          end
        end
        led_fade_pkg::PH_RISE: begin
          if (cfg_r.rise == 5'h00 || level_r == cfg_r.on_int) begin
            level_r <= cfg_r.on_int;
            phase_r <= led_fade_pkg::PH_ON;
            step_r  <= 9'h000;
          end else if (unit_tick && step_r + 9'h001 >= ramp_units(cfg_r.rise)) begin
            level_r <= step_toward(level_r, cfg_r.on_int);
            step_r  <= 9'h000;
          end else if (unit_tick) begin
            step_r <= step_r + 9'h001;
          end
        end
      endcase
    end
  end

  // PWM: 255 driver-clock periods per frame; the pin sinks while lit.
  always_ff @(posedge aclk) begin
    if (!aresetn || !enabled) begin
      pwm_r <= 8'h00;
    end else if (led_driver_clock_tick) begin
      pwm_r <= (pwm_r == led_fade_pkg::PWM_LAST) ? 8'h00 : pwm_r + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= enabled && pwm_r < duty;
    end
  end

  assign led_pin_value = 1'b0;
  assign led_pin_oe = oe_r;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  off_hold_a: assert property (
    (phase_r == led_fade_pkg::PH_OFF && cfg_r.off_time == 5'h00 && data_r && enabled)
    |=> phase_r == led_fade_pkg::PH_OFF)
    else $error("single shot OFF phase left while data high");

  off_fast_a: assert property (
    (phase_r == led_fade_pkg::PH_OFF && cfg_r.off_time inside {[1:15]})
    |-> dur_r < 14'(cfg_r.off_time) * 14'h0040)
    else $error("short OFF count exceeds its span");

  off_slow_a: assert property (
    (phase_r == led_fade_pkg::PH_OFF && cfg_r.off_time >= 5'h10)
    |-> dur_r < 14'(cfg_r.off_time) * 14'h0200)
    else $error("long OFF count exceeds its span");

  off_level_a: assert property (
    (enabled && $past(phase_r) == led_fade_pkg::PH_OFF && phase_r == led_fade_pkg::PH_OFF)
    |-> level_r == {3'h0, cfg_r.off_int, 2'h0})
    else $error("OFF intensity is not four times field");

  rise_fast_a: assert property (
    (phase_r == led_fade_pkg::PH_RISE && cfg_r.rise inside {[1:15]}) |-> step_r < 9'(cfg_r.rise))
    else $error("fade-in step interval too long");

  rise_slow_a: assert property (
    (phase_r == led_fade_pkg::PH_RISE && cfg_r.rise >= 5'h10) |-> step_r < 9'(cfg_r.rise) * 9'h010)
    else $error("slow fade-in step interval too long");

  fall_skip_a: assert property (
    (phase_r == led_fade_pkg::PH_FALL && cfg_r.fall == 5'h00 && enabled)
    |=> phase_r == led_fade_pkg::PH_OFF)
    else $error("disabled fade-out did not skip");

  dark_pin_a: assert property (
    !enabled |=> !led_pin_oe)
    else $error("pin driven with driver clock off");

  on_level_a: assert property (
    (phase_r == led_fade_pkg::PH_ON && $past(phase_r) == led_fade_pkg::PH_ON && enabled && $past(enabled))
    |-> level_r == $past(cfg_r.on_int))
    else $error("ON intensity differs from field");

  cycle_order_a: assert property (
    (phase_r == led_fade_pkg::PH_FALL && enabled) |=> phase_r inside {led_fade_pkg::PH_FALL, led_fade_pkg::PH_OFF})
    else $error("fade-out left to wrong phase");

  full_cycle_c: cover property (
    phase_r == led_fade_pkg::PH_RISE ##1 phase_r == led_fade_pkg::PH_ON);
  timed_fall_c: cover property (
    cfg_r.fall != 5'h00 && phase_r == led_fade_pkg::PH_FALL ##1 phase_r == led_fade_pkg::PH_OFF);
  pin_lit_c: cover property (cfg_r.log_mode && $rose(led_pin_oe));

endmodule : led_fade_channel

// ===== hw/led_fade_pkg.sv
// Purpose: Shared constants and types of the LED off-phase and fade timing channel.
// Assumes: AXI4-Lite register bus with 32-bit data; the oscillator is aclk.
// Notes:   Writable registers sit in the low byte of their word; STATUS spans bits 0 to 10.
package led_fade_pkg;

  // Register byte addresses.
  localparam logic [7:0] ADDR_ON_TIME  = 8'h00;
  localparam logic [7:0] ADDR_ON_INT   = 8'h04;
  localparam logic [7:0] ADDR_OFF      = 8'h08;
  localparam logic [7:0] ADDR_RISE     = 8'h0c;
  localparam logic [7:0] ADDR_FALL     = 8'h10;
  localparam logic [7:0] ADDR_MISC     = 8'h14;
  localparam logic [7:0] ADDR_DATA     = 8'h18;
  localparam logic [7:0] ADDR_STATUS   = 8'h1c;

  // Reset values.
  localparam logic [7:0] RST_ON_INT    = 8'hff;
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic       RST_DATA      = 1'b1;

  // Field positions.
  localparam int OFF_TIME_LO  = 3;
  localparam int OFF_INT_HI   = 2;
  localparam int MISC_DIV_LO  = 4;
  localparam int MISC_MODE    = 3;
  localparam int STAT_PHASE_LO = 8;
  localparam int STAT_PIN      = 10;

  // Timing factors; spans and ramp steps count 255-period units of the driver clock.
  localparam int FAST_LIMIT    = 16;
  localparam int SPAN_FAST     = 64;
  localparam int SPAN_SLOW     = 512;
  localparam int FADE_SLOW     = 16;
  localparam int OFF_INT_SCALE = 4;
  localparam logic [7:0] PWM_LAST = 8'hfe;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {PH_ON, PH_FALL, PH_OFF, PH_RISE} phase_t;

  typedef struct packed {
    logic [4:0] on_time;
    logic [7:0] on_int;
    logic [4:0] off_time;
    logic [2:0] off_int;
    logic [4:0] rise;
    logic [4:0] fall;
    logic       log_mode;
    logic [2:0] div;
  } led_cfg_t;

endpackage : led_fade_pkg

// ===== hw/led_tick_gen.sv
// Purpose: LED driver clock enable and the 255-period time unit.
// Assumes: The oscillator is aclk.
// Notes:   A divider of zero stops both ticks.
`timescale 1ns/1ns
module led_tick_gen (
  // Clock and reset.
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Control.
  input  wire logic [2:0] div,
  // Ticks.
  output logic            led_driver_clock_tick,
  output logic            unit_tick
);
  logic [5:0] pre_r;
  logic [7:0] unit_r;
  logic [5:0] pre_last;

  // The driver clock runs at the oscillator over 2 to the power (div - 1).
  assign pre_last = 6'((7'h01 << (div - 3'h1)) - 7'h01);

  always_ff @(posedge aclk) begin
    if (!aresetn || div == 3'h0) begin
      pre_r     <= 6'h00;
      led_driver_clock_tick <= 1'b0;
    end else if (pre_r >= pre_last) begin
      pre_r     <= 6'h00;
      led_driver_clock_tick <= 1'b1;
    end else begin
      pre_r     <= pre_r + 6'h01;
      led_driver_clock_tick <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || div == 3'h0) begin
      unit_r    <= 8'h00;
      unit_tick <= 1'b0;
    end else if (led_driver_clock_tick && unit_r == led_fade_pkg::PWM_LAST) begin
      unit_r    <= 8'h00;
      unit_tick <= 1'b1;
    end else begin
      unit_r    <= led_driver_clock_tick ? unit_r + 8'h01 : unit_r;
      unit_tick <= 1'b0;
    end
  end

endmodule : led_tick_gen

// ===== hw/led_level_map.sv
// Purpose: Maps a raw intensity to the PWM duty, linear or logarithmic.
// Assumes: The curve is a square law that keeps 0 and 255 fixed.
// Notes:   One cycle of latency in both modes.
`timescale 1ns/1ns
module led_level_map (
  // Clock and reset.
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Mapping.
  input  wire logic       log_mode,
  input  wire logic [7:0] level_in,
  output logic      [7:0] level_out
);
  function automatic logic [7:0] curve(input logic [7:0] x);
    logic [15:0] p;
    p = {8'h00, x} * {8'h00, x} + {8'h00, x};
    return p[15:8];
  endfunction : curve

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_out <= 8'h00;
    end else begin
      level_out <= log_mode ? curve(level_in) : level_in;
    end
  end

  log_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
    log_mode |=> level_out == curve($past(level_in)))
    else $error("log mapping output wrong");

endmodule : led_level_map

// ===== verification/led_sink_model.sv
// Purpose: LED hanging from a supply rail onto the open-drain channel pin.
// Assumes: The channel releases the pin whenever its output enable is low.
// Notes:   The LED conducts only while the pin is pulled low.
`timescale 1ns/1ns
module led_sink_model (
  // Pin side.
  input  wire logic pin_value,
  input  wire logic pin_oe,
  // Observed levels.
  output logic      pin_level,
  output logic      lit
);
  // A released pin is pulled up through the LED, so it never shows a stale low.
  assign pin_level = pin_oe ? pin_value : 1'b1;
  assign lit       = !pin_level;
endmodule : led_sink_model

// ===== verification/led_off_fade_timing_tb.sv
// Purpose: Register, duty and phase timing checks of the fade channel.
// Assumes: Divider 1 gives one driver tick per aclk, so a unit is 255 cycles.
// Notes:   Field values above 15 are only watched over their first few units.
`timescale 1ns/1ns
module led_off_fade_timing_tb;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, pin_value, pin_oe, pin_level, lit;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          fail_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          t0, t1;
  logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
  logic [31:0] rv [8] = '{32'h0, 32'hff, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h400};

  led_fade_channel dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .led_pin_sense(pin_level), .led_pin_value(pin_value), .led_pin_oe(pin_oe)
  );

  led_sink_model led_u (.pin_value(pin_value), .pin_oe(pin_oe), .pin_level(pin_level), .lit(lit));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  always @(posedge aclk) cyc <= cyc + 1;

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic timeout();
    fail_count++;
    $display("BAD wait expected answer seen none");
    wrap_up();
  endtask : timeout

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Spans may end up to one unit late, and polling adds a few cycles either side.
  task automatic chk_span(input string what, input int exp, input int got);
    total_checks++;
    if (got < exp - 10 || got > exp + 265) begin
      fail_count++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_span

  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er = led_fade_pkg::RESP_OKAY);
    int n;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h0, v};
    wstrb   <= 4'h1;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (n == 100) timeout();
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (n == 100) timeout();
    v = rdata;
    r = rresp;
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er = led_fade_pkg::RESP_OKAY);
    logic [1:0] r;
    rd(a, d, r);
    chk($sformatf("rdata at %h", a), ev, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask : rd_chk

  // The pin readback bit follows the PWM, so only phase and raw level are compared.
  task automatic stat_chk(input logic [9:0] ev);
    logic [1:0] r;
    rd(led_fade_pkg::ADDR_STATUS, d, r);
    chk("phase and level", {22'h0, ev}, {22'h0, d[9:0]});
  endtask : stat_chk

  task automatic wait_phase(input logic [1:0] ph, output int t);
    logic [1:0] r;
    for (int n = 0; n < 10000; n++) begin
      rd(led_fade_pkg::ADDR_STATUS, d, r);
      if (d[9:8] === ph) begin
        t = cyc;
        return;
      end
    end
    timeout();
  endtask : wait_phase

  // The window must span whole PWM frames: 255 driver ticks.
  task automatic duty(input int exp, input int len = 255);
    int n;
    n = 0;
    repeat (4) @(posedge aclk);
    repeat (len) begin
      @(posedge aclk);
      if (lit === 1'b1) n++;
    end
    chk("lit cycles per frame", exp, n);
  endtask : duty

  function automatic int logmap(input int x);
    return (x * x + x) >> 8;
  endfunction : logmap

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (ra[i]) rd_chk(ra[i], rv[i]);
    rd_chk(8'h20, 32'h0, led_fade_pkg::RESP_SLVERR);
    wr(led_fade_pkg::ADDR_STATUS, 8'h00, led_fade_pkg::RESP_SLVERR);
    wr(8'h09, 8'h00, led_fade_pkg::RESP_SLVERR);
    wr(led_fade_pkg::ADDR_RISE, 8'he1);
    rd_chk(led_fade_pkg::ADDR_RISE, 32'h01);
    wr(led_fade_pkg::ADDR_OFF, 8'ha5);
    rd_chk(led_fade_pkg::ADDR_OFF, 32'ha5);
    wr(led_fade_pkg::ADDR_OFF, 8'h05);
    wr(led_fade_pkg::ADDR_RISE, 8'h00);
    wr(led_fade_pkg::ADDR_ON_INT, 8'h80);
    wr(led_fade_pkg::ADDR_DATA, 8'h00);
    wr(led_fade_pkg::ADDR_MISC, 8'h10);
    duty(128);
    stat_chk({2'h0, 8'h80});
    wr(led_fade_pkg::ADDR_DATA, 8'h01);
    wait_phase(2'h2, t0);
    stat_chk({2'h2, 8'h14});
    duty(20);
    repeat (600) @(posedge aclk);
    stat_chk({2'h2, 8'h14});
    wr(led_fade_pkg::ADDR_MISC, 8'h18);
    duty(logmap(20));
    wr(led_fade_pkg::ADDR_DATA, 8'h00);
    wait_phase(2'h0, t1);
    stat_chk({2'h0, 8'h80});
    duty(logmap(128));
    wr(led_fade_pkg::ADDR_MISC, 8'h20);
    duty(256, 510);
    wr(led_fade_pkg::ADDR_MISC, 8'h00);
    stat_chk(10'h000);
    duty(0);
    wr(led_fade_pkg::ADDR_ON_TIME, 8'h01);
    wr(led_fade_pkg::ADDR_ON_INT, 8'h08);
    wr(led_fade_pkg::ADDR_OFF, 8'h09);
    wr(led_fade_pkg::ADDR_RISE, 8'h01);
    wr(led_fade_pkg::ADDR_FALL, 8'h01);
    wr(led_fade_pkg::ADDR_MISC, 8'h10);
    t0 = cyc;
    wait_phase(2'h1, t1);
    chk_span("on span", 64 * 255, t1 - t0);
    t0 = t1;
    wait_phase(2'h2, t1);
    chk_span("fall span", (8 - 4) * 255, t1 - t0);
    t0 = t1;
    stat_chk({2'h2, 8'h04});
    wait_phase(2'h3, t1);
    chk_span("off span", 64 * 255, t1 - t0);
    t0 = t1;
    wait_phase(2'h0, t1);
    chk_span("rise span", (8 - 4) * 255, t1 - t0);
    // A fast reading of value 16 would step once within 5000 cycles; the slow one must not.
    wr(led_fade_pkg::ADDR_ON_TIME, 8'h00);
    wr(led_fade_pkg::ADDR_FALL, 8'h10);
    wr(led_fade_pkg::ADDR_RISE, 8'h10);
    wr(led_fade_pkg::ADDR_OFF, 8'h81);
    wr(led_fade_pkg::ADDR_DATA, 8'h01);
    repeat (5000) @(posedge aclk);
    stat_chk({2'h1, 8'h08});
    wr(led_fade_pkg::ADDR_FALL, 8'h00);
    repeat (600) @(posedge aclk);
    stat_chk({2'h2, 8'h04});
    wr(led_fade_pkg::ADDR_OFF, 8'h01);
    wr(led_fade_pkg::ADDR_DATA, 8'h00);
    repeat (5000) @(posedge aclk);
    stat_chk({2'h3, 8'h04});
    wrap_up();
  end
endmodule : led_off_fade_timing_tb
